// ===== verilog/dsl_device.sv
// dsl_device: serial load port, register file and phase pipeline of the synthesiser.
// assumes the link pins arrive unsynchronised; clk_i is the master clock.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - each transfer is one 16-bit word
// - strobe is level frame sync and enable
// - bits ignored while strobe is high
// - shift on sclk falling edges, 16 pulses
// - host raises strobe after 16th fall
// - long frames split into 16-bit words
// - sclk high when strobe falls, may idle
// - host holds reset until output wanted
// - reset clears accumulator, output at midscale
// - reset keeps phase, frequency, control registers
// - host loads registers before releasing reset
// - output data eight cycles after reset
// - select pin change takes eight cycles
// - late select change costs one cycle
// - register load reaches output in 8-9
// - reset and sleep release sampled late
// - comparator needs sign and output-enable bits
// - accumulator fed from register a or b
// - address bits 00 mean control write
// - control bits except B28 and HLB sampled late
module dsl_device #(
  parameter int unsigned LAT = dsl_pkg::PIPE_LAT
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rstn_i,
  // link from the host
  dsl_if.device                             link,
  // synthesiser output
  output logic [dsl_pkg::PHASE_W-1:0]       dac_phase_o,
  output logic                              out_active_o,
  output logic                              comparator_en_o,
  output logic                              sleep_o,
  // received words
  output logic [dsl_pkg::WORD_W-1:0]        word_o,
  output logic                              word_valid_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [dsl_pkg::WORD_W-1:0]             shift;
    logic [dsl_pkg::CNT_W-1:0]              cnt;
    logic                                   sclk_prev;
    logic [dsl_pkg::WORD_W-1:0]             word;
    logic                                   word_v;
    logic [dsl_pkg::HALF_W-1:0]             ctrl;
    logic [dsl_pkg::HALF_W-1:0]             ctrl_late;
    logic [dsl_pkg::FREQ_W-1:0]             freq_a;
    logic [dsl_pkg::FREQ_W-1:0]             freq_b;
    logic [dsl_pkg::PHASE_W-1:0]            phase_a;
    logic [dsl_pkg::PHASE_W-1:0]            phase_b;
    logic [dsl_pkg::HALF_W-1:0]             lsb_hold;
    logic                                   lsb_pend;
    logic                                   rst_hold;
    logic                                   sleep_hold;
    logic [dsl_pkg::FREQ_W-1:0]             acc;
    logic [LAT-1:0][dsl_pkg::PHASE_W:0]     pipe;
  } dsl_dev_s;
  dsl_dev_s s_q, s_d;

  logic [dsl_pkg::LINK_W-1:0] pins;

  // pin or software source, chosen by the pin/software control bit
  function automatic logic pin_or_bit(input logic use_pin, input logic pin, input logic sw);
    pin_or_bit = use_pin ? pin : sw;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  dsl_sync #(
    .W    (dsl_pkg::LINK_W),
    .INIT (dsl_pkg::LINK_IDLE)
  ) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i ({link.reset_pin, link.phase_select_pin, link.frequency_select_pin,
               link.sdata, link.frame_strobe_n, link.sclk}),
    .level_o (pins)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [dsl_pkg::WORD_W-1:0]  shifted;
    logic [dsl_pkg::FREQ_W-1:0]  f;
    logic [dsl_pkg::HALF_W-1:0]  pay;
    logic                        frequency_select_bit_e;
    logic                        psel_e;
    logic                        rst_req;
    logic                        rst_e;
    logic                        sleep_e;
    shifted = {s_q.shift[dsl_pkg::WORD_W-2:0], pins[dsl_pkg::L_SDAT]};
    f       = '0;
    pay     = s_q.word[dsl_pkg::HALF_W-1:0];
    frequency_select_bit_e  = 1'b0;
    psel_e  = 1'b0;
    rst_req = 1'b0;
    rst_e   = 1'b0;
    sleep_e = 1'b0;
    s_d           = s_q;
    s_d.word_v    = 1'b0;
    s_d.sclk_prev = pins[dsl_pkg::L_SCLK];

    // serial shifter
    if (pins[dsl_pkg::L_STRB]) begin
      s_d.cnt = '0;
    end else if (s_q.sclk_prev && !pins[dsl_pkg::L_SCLK]) begin
      s_d.shift = shifted;
      if (s_q.cnt == dsl_pkg::LAST_BIT) begin
        s_d.cnt    = '0;
        s_d.word   = shifted;
        s_d.word_v = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end

    // word decode, one cycle after the word closes
    if (s_q.word_v) begin
      case (s_q.word[dsl_pkg::WORD_W-1 -: 2])
        dsl_pkg::ADDR_CTRL: begin
          s_d.ctrl = pay;
        end
        dsl_pkg::ADDR_FREQA, dsl_pkg::ADDR_FREQB: begin
          f = (s_q.word[dsl_pkg::WORD_W-1 -: 2] == dsl_pkg::ADDR_FREQA) ? s_q.freq_a
                                                                        : s_q.freq_b;
          // a 28-bit load commits only once both halves are in
          if (s_q.ctrl[dsl_pkg::C_B28]) begin
            if (!s_q.lsb_pend) begin
              s_d.lsb_hold = pay;
              s_d.lsb_pend = 1'b1;
            end else begin
              f            = {pay, s_q.lsb_hold};
              s_d.lsb_pend = 1'b0;
            end
          end else if (s_q.ctrl[dsl_pkg::C_HLB]) begin
            f[dsl_pkg::FREQ_W-1 -: dsl_pkg::HALF_W] = pay;
          end else begin
            f[dsl_pkg::HALF_W-1:0] = pay;
          end
          if (s_q.word[dsl_pkg::WORD_W-1 -: 2] == dsl_pkg::ADDR_FREQA) begin
            s_d.freq_a = f;
          end else begin
            s_d.freq_b = f;
          end
        end
        dsl_pkg::ADDR_PHASE: begin
          if (s_q.word[dsl_pkg::PH_SEL_POS]) begin
            s_d.phase_b = pay[dsl_pkg::PHASE_W-1:0];
          end else begin
            s_d.phase_a = pay[dsl_pkg::PHASE_W-1:0];
          end
        end
        default: begin
          s_d.ctrl = s_q.ctrl;
        end
      endcase
    end

    // control sampled one cycle late, standing in for the falling-edge sample
    s_d.ctrl_late = s_q.ctrl;
    frequency_select_bit_e  = pin_or_bit(s_q.ctrl_late[dsl_pkg::C_PINSW], pins[dsl_pkg::L_FREQUENCY_SELECT_BIT],
                         s_q.ctrl_late[dsl_pkg::C_FREQUENCY_SELECT_BIT]);
    psel_e  = pin_or_bit(s_q.ctrl_late[dsl_pkg::C_PINSW], pins[dsl_pkg::L_PSEL],
                         s_q.ctrl_late[dsl_pkg::C_PSEL]);
    rst_req = pin_or_bit(s_q.ctrl_late[dsl_pkg::C_PINSW], pins[dsl_pkg::L_RST],
                         s_q.ctrl_late[dsl_pkg::C_RESET]);

    // release of reset and sleep is seen one cycle late, assertion at once
    s_d.rst_hold   = rst_req;
    s_d.sleep_hold = s_q.ctrl_late[dsl_pkg::C_SLEEP1];
    rst_e   = rst_req | s_q.rst_hold;
    sleep_e = s_q.ctrl_late[dsl_pkg::C_SLEEP1] | s_q.sleep_hold;

    // accumulator; registers themselves are never touched by the reset function
    if (rst_e) begin
      s_d.acc = '0;
    end else if (!sleep_e) begin
      s_d.acc = s_q.acc + (frequency_select_bit_e ? s_q.freq_b : s_q.freq_a);
    end

    // output pipeline sets the fixed latency to the dac
    s_d.pipe[0] = rst_e ? '0 : {1'b1, s_q.acc[dsl_pkg::FREQ_W-1 -: dsl_pkg::PHASE_W]
                               + (psel_e ? s_q.phase_b : s_q.phase_a)};
    for (int i = 1; i < int'(LAT); i++) begin
      s_d.pipe[i] = s_q.pipe[i-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers; register contents after power-up are zero, not meaningful
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign dac_phase_o     = s_q.pipe[LAT-1][dsl_pkg::PHASE_W-1:0];
  assign out_active_o    = s_q.pipe[LAT-1][dsl_pkg::PHASE_W];
  assign comparator_en_o = s_q.ctrl_late[dsl_pkg::C_SIGN]
                         & s_q.ctrl_late[dsl_pkg::C_OPBEN];
  assign sleep_o         = s_q.ctrl_late[dsl_pkg::C_SLEEP1];
  assign word_o          = s_q.word;
  assign word_valid_o    = s_q.word_v;
endmodule // dsl_device
`default_nettype wire

// ===== verilog/dsl_pkg.sv
// dsl_pkg: constants shared by the serial load port, its host end and the dds core.
// assumes a single 40 MHz master clock on both ends.
`default_nettype none
package dsl_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // serial word and dds widths
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned CNT_W   = 5;
  localparam int unsigned FREQ_W  = 28;
  localparam int unsigned PHASE_W = 12;
  localparam int unsigned HALF_W  = 14;
  localparam int unsigned PIPE_LAT = 8;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;
  ////////////////////////////////////////////////////////////////////////////////
  // word address codes, bits 15:14
  localparam logic [1:0] ADDR_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_FREQA = 2'h1;
  localparam logic [1:0] ADDR_FREQB = 2'h2;
  localparam logic [1:0] ADDR_PHASE = 2'h3;
  localparam int unsigned PH_SEL_POS = 13;
  ////////////////////////////////////////////////////////////////////////////////
  // control field positions
  localparam int unsigned C_B28    = 13;
  localparam int unsigned C_HLB    = 12;
  localparam int unsigned C_FREQUENCY_SELECT_BIT   = 11;
  localparam int unsigned C_PSEL   = 10;
  localparam int unsigned C_PINSW  = 9;
  localparam int unsigned C_RESET  = 8;
  localparam int unsigned C_SLEEP1 = 7;
  localparam int unsigned C_OPBEN  = 5;
  localparam int unsigned C_SIGN   = 4;
  ////////////////////////////////////////////////////////////////////////////////
  // link pin vector order inside the device, and its idle level
  localparam int unsigned L_SCLK = 0;
  localparam int unsigned L_STRB = 1;
  localparam int unsigned L_SDAT = 2;
  localparam int unsigned L_FREQUENCY_SELECT_BIT = 3;
  localparam int unsigned L_PSEL = 4;
  localparam int unsigned L_RST  = 5;
  localparam int unsigned LINK_W = 6;
  localparam logic [5:0]  LINK_IDLE = 6'h03;
  ////////////////////////////////////////////////////////////////////////////////
  // host timing and register map
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned SCLK_PERIOD_NS = 200;
  localparam int unsigned SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [7:0]  REG_TXDATA = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_PINS   = 8'h08;
  localparam logic [2:0]  PINS_RESET_VAL = 3'h4;
endpackage
`default_nettype wire

// ===== verilog/dsl_if.sv
// dsl_if: three-wire load link plus select and reset pins between host and device.
// assumes the host drives every wire; the device only listens.
`timescale 1ns/1ps
`default_nettype none
interface dsl_if;
  logic sclk;
  logic frame_strobe_n;
  logic sdata;
  logic frequency_select_pin;
  logic phase_select_pin;
  logic reset_pin;
  modport host (
    output sclk, frame_strobe_n, sdata, frequency_select_pin, phase_select_pin, reset_pin
  );
  modport device (
    input sclk, frame_strobe_n, sdata, frequency_select_pin, phase_select_pin, reset_pin
  );
endinterface
`default_nettype wire

// ===== verilog/dsl_sync.sv
// dsl_sync: three-stage synchroniser with agreement filter for pins from another domain.
// assumes clk_i is the local clock; a change is taken once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module dsl_sync #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // pins in, filtered level out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } dsl_sync_s;
  dsl_sync_s s_q, s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = async_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // s1 only feeds s2, so a metastable first stage never reaches logic
    for (int i = 0; i < int'(W); i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.lvl[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.lvl;
endmodule // dsl_sync
`default_nettype wire

// ===== verilog/dsl_host.sv
// dsl_host: apb-controlled master that sends 16-bit words and drives the select pins.
// assumes an apb master on clk_i; sclk is divided down from clk_i.
`timescale 1ns/1ps
`default_nettype none
module dsl_host #(
  parameter int unsigned HALF_CYC = dsl_pkg::SCLK_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // link to the device
  dsl_if.host              link
);
  typedef enum logic [1:0] {
    DSL_IDLE,
    DSL_LOW,
    DSL_HIGH,
    DSL_TAIL
  } dsl_host_e;

  typedef struct packed {
    dsl_host_e                  st;
    logic [7:0]                 div;
    logic                       sclk;
    logic                       strobe_n;
    logic [dsl_pkg::WORD_W-1:0] shift;
    logic [dsl_pkg::WORD_W-1:0] last;
    logic [dsl_pkg::CNT_W-1:0]  cnt;
    logic [2:0]                 pins;
    logic [31:0]                rdata;
  } dsl_host_s;
  dsl_host_s s_q, s_d;

  logic busy;
  logic access;
  logic mapped;
  logic refused;
  logic tick;

  assign busy    = (s_q.st != DSL_IDLE);
  assign access  = psel_i & penable_i;
  assign mapped  = (paddr_i == dsl_pkg::REG_TXDATA) | (paddr_i == dsl_pkg::REG_STATUS)
                 | (paddr_i == dsl_pkg::REG_PINS);
  // a new word while one is still going out is refused, not queued
  assign refused = pwrite_i & busy & (paddr_i == dsl_pkg::REG_TXDATA);
  assign tick    = (s_q.div == 8'(HALF_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d     = s_q;
    s_d.div = tick ? 8'h00 : s_q.div + 8'h01;

    // read data captured in the setup cycle so it is stable for the access cycle
    if (psel_i && !penable_i) begin
      case (paddr_i)
        dsl_pkg::REG_TXDATA: s_d.rdata = {16'h0000, s_q.last};
        dsl_pkg::REG_STATUS: s_d.rdata = {31'h00000000, busy};
        dsl_pkg::REG_PINS:   s_d.rdata = {29'h00000000, s_q.pins};
        default:             s_d.rdata = 32'h00000000;
      endcase
    end

    if (access && pwrite_i && mapped && !refused) begin
      if (paddr_i == dsl_pkg::REG_PINS) begin
        s_d.pins = pwdata_i[2:0];
      end
      if (paddr_i == dsl_pkg::REG_TXDATA) begin
        s_d.shift    = pwdata_i[15:0];
        s_d.last     = pwdata_i[15:0];
        s_d.cnt      = '0;
        s_d.strobe_n = 1'b0;
        s_d.st       = DSL_LOW;
        s_d.div      = 8'h00;
      end
    end

    if (tick) begin
      case (s_q.st)
        DSL_LOW: begin
          s_d.sclk = 1'b0;
          s_d.st   = DSL_HIGH;
        end
        DSL_HIGH: begin
          s_d.sclk = 1'b1;
          if (s_q.cnt == dsl_pkg::LAST_BIT) begin
            s_d.st = DSL_TAIL;
          end else begin
            s_d.cnt   = s_q.cnt + 5'h01;
            s_d.shift = {s_q.shift[dsl_pkg::WORD_W-2:0], 1'b0};
            s_d.st    = DSL_LOW;
          end
        end
        DSL_TAIL: begin
          s_d.strobe_n = 1'b1;
          s_d.st       = DSL_IDLE;
        end
        default: begin
          s_d.st = s_q.st;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q          <= '0;
      s_q.st       <= DSL_IDLE;
      s_q.sclk     <= 1'b1;
      s_q.strobe_n <= 1'b1;
      s_q.pins     <= dsl_pkg::PINS_RESET_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata_o                  = s_q.rdata;
  assign pready_o                  = 1'b1;
  assign pslverr_o                 = access & (!mapped | refused);
  assign link.sclk                 = s_q.sclk;
  assign link.frame_strobe_n       = s_q.strobe_n;
  assign link.sdata                = s_q.shift[dsl_pkg::WORD_W-1];
  assign link.frequency_select_pin = s_q.pins[0];
  assign link.phase_select_pin     = s_q.pins[1];
  assign link.reset_pin            = s_q.pins[2];
endmodule // dsl_host
`default_nettype wire

// ===== verif/dsl_sva.sv
// dsl_sva: checks on the host-device link and the device outputs.
// assumes every input sits in the clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module dsl_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // link and device outputs
  input wire logic        sclk,
  input wire logic        frame_strobe_n,
  input wire logic        sdata,
  input wire logic        reset_pin,
  input wire logic        out_active_o,
  input wire logic        comparator_en_o,
  input wire logic [15:0] word_o,
  input wire logic        word_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // helper: falls per frame, shifted bits, last control word and its age
  logic [7:0]  falls_q;
  logic [15:0] shift_q;
  logic [15:0] ctl_q;
  logic [3:0]  age_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      falls_q <= 8'h00;
      shift_q <= 16'h0000;
      ctl_q   <= 16'h0000;
      age_q   <= 4'hF;
    end else begin
      if (frame_strobe_n) falls_q <= 8'h00;
      else if ($fell(sclk)) begin
        falls_q <= falls_q + 8'h01;
        shift_q <= {shift_q[14:0], sdata};
      end
      if (word_valid_o && word_o[15:14] == 2'h0) begin
        ctl_q <= word_o;
        age_q <= 4'h0;
      end else if (age_q != 4'hF) age_q <= age_q + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_start_high;
    $fell(frame_strobe_n) |-> sclk;
  endproperty
  a_start_high: assert property (p_start_high) else $error("sclk low at frame start");
  property p_idle_high;
    frame_strobe_n |-> sclk;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("sclk not idle high");
  property p_whole_words;
    $rose(frame_strobe_n) |-> falls_q != 8'h00 && falls_q[3:0] == 4'h0;
  endproperty
  a_whole_words: assert property (p_whole_words) else $error("frame not whole words");
  property p_data_stable;
    !frame_strobe_n && !sclk && !$fell(sclk) |-> $stable(sdata);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("sdata moved in low half");
  property p_word_due;
    $fell(sclk) && !frame_strobe_n && falls_q[3:0] == 4'hF |-> ##[2:8] word_valid_o;
  endproperty
  a_word_due: assert property (p_word_due) else $error("no word after 16 falls");
  property p_msb_first;
    word_valid_o |-> word_o == shift_q;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("word bit order wrong");
  property p_pulse;
    word_valid_o |=> !word_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("word valid too long");
  property p_idle_quiet;
    frame_strobe_n [*8] |-> !word_valid_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("word while strobe high");
  property p_comp;
    age_q == 4'hF |-> comparator_en_o == (ctl_q[dsl_pkg::C_OPBEN] && ctl_q[dsl_pkg::C_SIGN]);
  endproperty
  a_comp: assert property (p_comp) else $error("comparator enable wrong");
  sequence s_rst_on;
    reset_pin && ctl_q[dsl_pkg::C_PINSW] && age_q == 4'hF;
  endsequence
  property p_midscale;
    s_rst_on [*8] ##1 s_rst_on [*8] |-> !out_active_o;
  endproperty
  a_midscale: assert property (p_midscale) else $error("output active in reset");
  // pin path: sync plus late release plus the eight-stage pipe
  property p_release;
    $fell(reset_pin) && ctl_q[dsl_pkg::C_PINSW] && age_q == 4'hF
      |-> (!out_active_o) [*8] ##[1:10] out_active_o;
  endproperty
  a_release: assert property (p_release) else $error("reset release latency");
  c_word: cover property (word_valid_o);
  c_release: cover property ($fell(reset_pin));
  c_comp: cover property ($rose(comparator_en_o));
endmodule // dsl_sva
`default_nettype wire

// ===== verif/dds_serial_load_and_latency_test.sv
// dds_serial_load_and_latency_test: host and device joined, plus a bench-driven device.
// assumes one 40 MHz clk_i for all ends and apb driven from the bench.
`timescale 1ns/1ps
`default_nettype none
module dds_serial_load_and_latency_test;
  logic        clk_i;
  logic        rstn_i;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er, act1, cmp1, v1, v2, slp1;
  logic [11:0] ph1;
  logic [15:0] w1, w2, last1;
  logic [15:0] q2[$];
  int          n_errors, total_checks, n1;
  dsl_if link ();
  dsl_if lk2 ();
  dsl_host dsl_host_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .link(link));
  dsl_device dsl_device_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .dac_phase_o(ph1),
    .out_active_o(act1), .comparator_en_o(cmp1), .sleep_o(slp1), .word_o(w1), .word_valid_o(v1));
  // second device faces the bench, which breaks framing on purpose
  dsl_device dsl_device_inst_2 (.clk_i(clk_i), .rstn_i(rstn_i), .link(lk2), .dac_phase_o(),
    .out_active_o(), .comparator_en_o(), .sleep_o(), .word_o(w2), .word_valid_o(v2));
  dsl_sva dsl_sva_inst (.clk_i(clk_i), .rstn_i(rstn_i), .sclk(link.sclk),
    .frame_strobe_n(link.frame_strobe_n), .sdata(link.sdata), .reset_pin(link.reset_pin),
    .out_active_o(act1), .comparator_en_o(cmp1), .word_o(w1), .word_valid_o(v1));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (v1 === 1'b1) begin
      last1 <= w1;
      n1 <= n1 + 1;
    end
    if (v2 === 1'b1) q2.push_back(w2);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic lost();
    n_errors++;
    test_done();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (k >= 64) lost();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (2) @(posedge clk_i);
    do begin
      apb(1'b0, dsl_pkg::REG_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 200);
    if (k >= 200) lost();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic send(input logic [15:0] w);
    apb(1'b1, dsl_pkg::REG_TXDATA, {16'h0, w});
    check(er, 1'b0);
    wait_idle();
    check(last1, w);
  endtask
  // cycles until the phase output or the active flag reaches tgt
  task automatic lat(input logic ph, input logic [11:0] tgt, output int n);
    n = 0;
    while ((ph ? ph1 : {11'h0, act1}) !== tgt && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 60) lost();
  endtask
  task automatic frame2(input logic [31:0] d, input int n, input logic en);
    @(posedge clk_i);
    lk2.frame_strobe_n <= ~en;
    lk2.sdata <= d[n-1];
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge clk_i);
      lk2.sclk <= 1'b0;
      repeat (4) @(posedge clk_i);
      lk2.sclk <= 1'b1;
      if (i > 0) lk2.sdata <= d[i-1];
    end
    repeat (4) @(posedge clk_i);
    lk2.frame_strobe_n <= 1'b1;
    lk2.sdata <= ~d[0];
    repeat (12) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, dsl_pkg::REG_PINS, 32'h0);
    check(rd, {29'h0, dsl_pkg::PINS_RESET_VAL});
    apb(1'b0, 8'h0C, 32'h0);
    check(er, 1'b1);
    apb(1'b1, dsl_pkg::REG_TXDATA, 32'h0200);
    apb(1'b1, dsl_pkg::REG_TXDATA, 32'h0000);
    check(er, 1'b1);
    wait_idle();
    check(last1, 16'h0200);
  endtask
  task automatic t_words();
    logic [15:0] ws [4] = '{16'h4000, 16'h8000, 16'hC000, 16'hE400};
    int n0;
    n0 = n1;
    foreach (ws[i]) send(ws[i]);
    check(n1 - n0, 4);
  endtask
  task automatic t_comp();
    for (int i = 0; i < 4; i++) begin
      send(16'h0200 | 16'(i << 4));
      repeat (16) @(posedge clk_i);
      check(cmp1, i == 3);
    end
    send(16'h02B0);
    check(slp1, 1'b1);
    send(16'h0230);
    check(slp1, 1'b0);
    send(16'h4000);
    check(cmp1, 1'b1);
  endtask
  task automatic t_reset();
    int n;
    check(act1, 1'b0);
    apb(1'b1, dsl_pkg::REG_PINS, 32'h0);
    lat(1'b0, 12'h001, n);
    check(n >= 9 && n <= 17, 1'b1);
    check(cmp1, 1'b1);
  endtask
  task automatic t_select();
    int n;
    int k;
    check(ph1, 12'h000);
    apb(1'b1, dsl_pkg::REG_PINS, 32'h2);
    lat(1'b1, 12'h400, n);
    check(n >= 9 && n <= 14, 1'b1);
    apb(1'b1, dsl_pkg::REG_TXDATA, 32'hE800);
    k = 0;
    while (v1 !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) lost();
    lat(1'b1, 12'h800, n);
    check(n >= 8 && n <= 12, 1'b1);
    wait_idle();
    send(16'h2200);
    send(16'h7FFF);
    check(ph1, 12'h800);
  endtask
  task automatic t_link();
    frame2(32'hA5C3, 16, 1'b0);
    check(q2.size(), 0);
    frame2(32'h1234_8001, 32, 1'b1);
    check(q2.size(), 2);
    check(q2[0], 16'h1234);
    check(q2[1], 16'h8001);
    frame2(32'h7F, 7, 1'b1);
    frame2(32'h5A5A, 16, 1'b1);
    check(q2.size(), 3);
    check(q2[2], 16'h5A5A);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lk2.sclk = 1'b1;
    lk2.frame_strobe_n = 1'b1;
    lk2.sdata = 1'b0;
    lk2.frequency_select_pin = 1'b0;
    lk2.phase_select_pin = 1'b0;
    lk2.reset_pin = 1'b0;
    n_errors = 0;
    total_checks = 0;
    n1 = 0;
    last1 = 16'h0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_words();
    t_comp();
    t_reset();
    t_select();
    t_link();
    test_done();
  end
endmodule // dds_serial_load_and_latency_test
`default_nettype wire
